// File: pim_pkg.sv
// Constants shared by the alert summary and enable logic.
package pim_pkg;
  // Register map.
  localparam logic [7:0] SUMMARY_ADDR    = 8'h00;
  localparam logic [7:0] ENABLE_ADDR     = 8'h01;
  localparam logic [7:0] GLOBAL_CMD_ADDR = 8'h0B;
  // Reset values.
  localparam logic [7:0] SUMMARY_RESET   = 8'h20;
  localparam logic [7:0] ENABLE_RESET    = 8'h80;
  // Enable register bit positions.
  localparam int EN_PWRENA     = 0;
  localparam int EN_PWRGD      = 1;
  localparam int EN_DET        = 2;
  localparam int EN_CLASS      = 3;
  localparam int EN_DISCONNECT = 4;
  localparam int EN_STARTFAULT = 5;
  localparam int EN_IFAULT     = 6;
  localparam int EN_GLOBAL     = 7;
  // Command register action bits.
  localparam int CMD_RELEASE   = 6;
  localparam int CMD_CLEAR     = 7;
  // Port event register layout: bits 0..5 map to enable bits 0..5,
  // bits 6 and 7 are the cut-off and current-limit timeouts.
  localparam int EV_TCUT       = 6;
  localparam int EV_TLIM       = 7;
  localparam int NUM_PORTS     = 4;
endpackage

// File: pim_gate_if.sv
// Carrier between the alert core and its event gating stage.
`timescale 1ns/1ns
`default_nettype none
interface pim_gate_if;
  logic [3:0][7:0] port_events;
  logic [3:0]      global_events;
  logic [7:0]      enable;
  logic [7:0]      cause;
  modport core (output port_events, output global_events, output enable,
                input cause);
  modport gate (input port_events, input global_events, input enable,
                output cause);
endinterface
`default_nettype wire

// File: pim_event_gate.sv
// Per-type gating of port and global events by the enable register.
`timescale 1ns/1ns
`default_nettype none
module pim_event_gate (
  pim_gate_if.gate g
);
  wire [7:0] type_any;
  wire [7:0] raw_type;

  // Collapse each event type across all ports.
  genvar t;
  generate
    for (t = 0; t < 8; t++) begin : g_type
      assign raw_type[t] = g.port_events[0][t] | g.port_events[1][t] |
                           g.port_events[2][t] | g.port_events[3][t];
    end
  endgenerate

  // Both timeouts share one enable bit; global faults share the top one.
  assign type_any[5:0] = raw_type[5:0];
  assign type_any[6]   = raw_type[pim_pkg::EV_TCUT] |
                         raw_type[pim_pkg::EV_TLIM];
  assign type_any[7]   = |g.global_events;

  // Enable 1 passes a type, enable 0 blocks it.
  assign g.cause = type_any & g.enable;
endmodule
`default_nettype wire

// File: pim_alert_core.sv
// Alert summary, alert enable and active-low alert output of the controller.
`timescale 1ns/1ns
`default_nettype none
module pim_alert_core (
  // Clock and reset.
  input  wire logic       CLK,
  input  wire logic       NRST,
  // Register access from the serial interface engine.
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  output logic      [7:0] REG_RDATA,
  // Event sources from the port and global event registers.
  input  wire logic [7:0] PORT1_EVENTS,
  input  wire logic [7:0] PORT2_EVENTS,
  input  wire logic [7:0] PORT3_EVENTS,
  input  wire logic [7:0] PORT4_EVENTS,
  input  wire logic [3:0] GLOBAL_EVENTS,
  // Alert pin, open drain.
  output logic            ALERT_N_O,
  output logic            ALERT_N_OE
);
  // ****************************************************************
  // Decode
  // ****************************************************************
  pim_gate_if gif ();

  logic [7:0] enable_q;
  logic [7:0] summary_q;
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  logic [7:0] cause_prev_q;
  logic       release_q;
  logic       release_d;

  // The write strobes and the read mux share one address decode, so a
  // register is selected in the same way for either direction.
  wire        sel_summary = (REG_ADDR == pim_pkg::SUMMARY_ADDR);
  wire        sel_enable  = (REG_ADDR == pim_pkg::ENABLE_ADDR);
  wire        sel_cmd     = (REG_ADDR == pim_pkg::GLOBAL_CMD_ADDR);

  // Writes to the read-only summary or to unmapped addresses are dropped
  // here. The command register keeps no state: its bits act only in the
  // cycle of the write, so a later write cannot repeat an old action.
  wire        wr_enable  = REG_WR && sel_enable;
  wire        wr_cmd     = REG_WR && sel_cmd;
  wire        cmd_clear  = wr_cmd && REG_WDATA[pim_pkg::CMD_CLEAR];
  wire        cmd_rel    = wr_cmd && REG_WDATA[pim_pkg::CMD_RELEASE];

  wire  [7:0] src;
  wire  [7:0] summary_d;
  wire  [7:0] cause_rise;
  wire        alert_any;
  wire  [7:0] rdata_d;

  assign gif.port_events   = {PORT4_EVENTS, PORT3_EVENTS,
                              PORT2_EVENTS, PORT1_EVENTS};
  assign gif.global_events = GLOBAL_EVENTS;
  assign gif.enable        = enable_q;

  pim_event_gate u_gate (
    .g (gif.gate)
  );

  // ****************************************************************
  // Summary
  // ****************************************************************
  // Low nibble is the OR of each port's events, high nibble mirrors
  // the global faults; the enable register plays no part here.
  // One loop keeps the four port bits identical by construction.
  genvar k;
  generate
    for (k = 0; k < pim_pkg::NUM_PORTS; k++) begin : g_port
      assign src[k] = |gif.port_events[k];
    end
  endgenerate
  assign src[7:4] = GLOBAL_EVENTS;

  // A clear hides a bit until its source has dropped, so an event that
  // is still standing does not reappear at once; a fresh one does.
  always_comb begin
    hold_d = hold_q & src;
    if (cmd_clear) begin
      hold_d = src;
    end
  end

  // Masking with the next hold value rather than the current one makes a
  // clear take effect at the very edge that accepts the write.
  assign summary_d = src & ~hold_d;

  // ****************************************************************
  // Alert
  // ****************************************************************
  // A release holds until a new enabled cause appears; a cause rising
  // in the release cycle wins so no event is lost.
  // Rising edges are taken per event type, so a second type becoming
  // active re-arms the pin even while an older one still stands.
  // The limitation is that a type which stays active all the time
  // cannot raise the pin again once software has released it.
  assign cause_rise = gif.cause & ~cause_prev_q;
  assign alert_any  = |gif.cause;

  always_comb begin
    release_d = release_q;
    if (cmd_rel) begin
      release_d = 1'b1;
    end
    if (|cause_rise || !alert_any) begin
      release_d = 1'b0;
    end
  end

  // ****************************************************************
  // Readback
  // ****************************************************************
  // Unmapped addresses and the command register read as zero, so
  // software never sees a stale byte of another register.
  assign rdata_d = sel_summary ? summary_q :
                   sel_enable  ? enable_q  :
                   8'h00;

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      enable_q <= pim_pkg::ENABLE_RESET;
    end else if (wr_enable) begin
      enable_q <= REG_WDATA;
    end
  end

  // The summary shows its reset pattern only until the first edge after
  // reset; from then on it follows its sources.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      summary_q <= pim_pkg::SUMMARY_RESET;
    end else begin
      summary_q <= summary_d;
    end
  end

  // Nothing is hidden after reset, so a standing event shows at once.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hold_q <= 8'h00;
    end else begin
      hold_q <= hold_d;
    end
  end

  // Starting from zero lets an event standing at reset count as new.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cause_prev_q <= 8'h00;
    end else begin
      cause_prev_q <= gif.cause;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      release_q <= 1'b0;
    end else begin
      release_q <= release_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // The pin is open drain: its data is tied low and only the enable
  // moves, so the pin can share a wired alert line with other devices.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ALERT_N_O <= 1'b0;
    end else begin
      ALERT_N_O <= 1'b0;
    end
  end

  // The next release value is used so that the pin lets go at the same
  // edge that accepts the release write.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ALERT_N_OE <= 1'b0;
    end else begin
      ALERT_N_OE <= alert_any && !release_d;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// File: pim_host.sv
// Host model that drives the register port of the alert core.
`timescale 1ns/1ns
`default_nettype none
module pim_host (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            we
);
  initial {addr, wdata, we} = 17'h0;
  // Released data is inverted so that a stale byte is never reused.
  task automatic wr(input logic [7:0] a_i, input logic [7:0] d_i);
    @(posedge clk) {addr, wdata, we} <= {a_i, d_i, 1'b1};
    @(posedge clk) {wdata, we} <= {~d_i, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a_i, output logic [7:0] q);
    @(posedge clk) addr <= a_i;
    @(posedge clk) #1 q = rdata;
  endtask
endmodule
`default_nettype wire

// File: pim_alert_checker.sv
// Assertions on the ports of the alert core.
`timescale 1ns/1ns
`default_nettype none
module pim_alert_checker (
  input wire logic       CLK, NRST, REG_WR, ALERT_N_O, ALERT_N_OE,
  input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
  input wire logic [7:0] PORT1_EVENTS, PORT2_EVENTS,
  input wire logic [7:0] PORT3_EVENTS, PORT4_EVENTS,
  input wire logic [3:0] GLOBAL_EVENTS
);
  logic [7:0] en_q, ev, cs;
  logic [1:0] up_q;
  assign ev = PORT1_EVENTS | PORT2_EVENTS | PORT3_EVENTS | PORT4_EVENTS;
  assign cs = {|GLOBAL_EVENTS, |ev[7:6], ev[5:0]} & en_q;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      {en_q, up_q} <= 10'h200;
    end else begin
      if (REG_WR && REG_ADDR == 8'h01) en_q <= REG_WDATA;
      if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  drain_low_a: assert property (!ALERT_N_O)
    else $error("alert data not low");
  no_cause_a: assert property (cs == 8'h00 |=> !ALERT_N_OE)
    else $error("alert without enabled cause");
  new_cause_a: assert property ((cs & ~$past(cs)) != 0 |=> ALERT_N_OE)
    else $error("enabled cause missed");
  release_a: assert property (up_q != 2'h0 &&
    REG_WR && REG_ADDR == 8'h0B && REG_WDATA[6] &&
    (cs & ~$past(cs)) == 0 |=> !ALERT_N_OE) else $error("no release");
  rd_enable_a: assert property (REG_ADDR == 8'h01 |=>
    REG_RDATA == $past(en_q)) else $error("enable readback wrong");
  port_idle_a: assert property (up_q == 2'h3 && REG_ADDR == 8'h00 &&
    $past(PORT1_EVENTS) == 0 |=> !REG_RDATA[0]) else $error("port bit");
  glob_idle_a: assert property (up_q == 2'h3 && REG_ADDR == 8'h00 &&
    $past(GLOBAL_EVENTS) == 0 |=> REG_RDATA[7:4] == 0) else $error("glob");
  clear_sum_a: assert property (REG_WR &&
    REG_ADDR == 8'h0B && REG_WDATA[7]
    ##1 $stable(PORT1_EVENTS) ##1 $stable(PORT1_EVENTS) && REG_ADDR == 8'h00
    |=> !REG_RDATA[0]) else $error("summary not cleared");
  cover property (ALERT_N_OE);
  cover property ($fell(ALERT_N_OE));
  cover property (REG_WR && REG_ADDR == 8'h0B);
endmodule
bind pim_alert_core pim_alert_checker u_chk (.*);
`default_nettype wire

// File: testbench.sv
// Self-checking bench of the alert core against an integer model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 0, nrst = 0, w, o, oe;
  logic [7:0] p[4], a, d, r, q, en, m;
  logic [3:0] g;
  int n_fail = 0, num_checks = 0;
  always #20 clk = ~clk;
  pim_host i_host (.clk(clk), .rdata(r), .addr(a), .wdata(d), .we(w));
  pim_alert_core i_dut (.CLK(clk), .NRST(nrst), .REG_ADDR(a),
    .REG_WDATA(d), .REG_WR(w), .REG_RDATA(r), .PORT1_EVENTS(p[0]),
    .PORT2_EVENTS(p[1]), .PORT3_EVENTS(p[2]), .PORT4_EVENTS(p[3]),
    .GLOBAL_EVENTS(g), .ALERT_N_O(o), .ALERT_N_OE(oe));
  function automatic int sum_m();
    int s = int'(g) << 4;
    for (int i = 0; i < 4; i++) if (p[i] != 0) s |= 1 << i;
    return s;
  endfunction
  function automatic int cause_m();
    int c = 0;
    for (int i = 0; i < 4; i++) c |= int'(p[i]);
    c = (c & 63) | (c > 63 ? 64 : 0) | (g != 0 ? 128 : 0);
    return c & int'(en);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #80000 n_fail++;
    wrap_up();
  end
  initial begin
    void'($urandom(49));
    g = 0;
    foreach (p[k]) p[k] = 0;
    repeat (3) @(posedge clk);
    nrst <= 1;
    i_host.rd(8'h01, q); chk(q, 8'h80);
    // Nine passes walk every event type, the rest are random.
    for (int i = 0; i < 25; i++) begin
      @(posedge clk);
      foreach (p[k]) p[k] <= (i < 8 && k == i % 4) ? 8'h01 << i :
        (i > 8 && $urandom % 3 == 0) ? 8'h01 << ($urandom % 8) : 8'h00;
      g <= (i == 8 || (i > 8 && $urandom % 4 == 0)) ? 4'h8 : 4'h0;
      m = i < 6 ? 8'h01 << i : i < 8 ? 8'h40 : i == 8 ? 8'h80 : 8'($urandom);
      for (int j = 0; j < 2; j++) begin
        en = j ? ~m : m;
        i_host.wr(8'h01, en);
        i_host.rd(8'h00, q); chk(q, 8'(sum_m()));
        chk(8'(oe), 8'(cause_m() != 0));
      end
    end
    @(posedge clk);
    foreach (p[k]) p[k] <= k == 0 ? 8'h02 : 8'h00;
    g <= 4'h0;
    i_host.wr(8'h01, 8'h03);
    i_host.wr(8'h0B, 8'h40);
    @(posedge clk) #1 chk({7'h0, oe}, 8'h00);
    @(posedge clk) p[1] <= 8'h01;
    repeat (2) @(posedge clk);
    #1 chk({7'h0, oe}, 8'h01);
    chk({7'h0, o}, 8'h00);
    i_host.wr(8'h0B, 8'h80);
    i_host.rd(8'h00, q); chk(q, 8'h00);
    @(posedge clk) p[0] <= 8'h00;
    @(posedge clk) p[0] <= 8'h02;
    i_host.rd(8'h00, q); chk(q, 8'h01);
    i_host.wr(8'h00, 8'hFF);
    i_host.rd(8'h05, q); chk(q, 8'h00);
    i_host.rd(8'h01, q); chk(q, 8'h03);
    wrap_up();
  end
endmodule
`default_nettype wire
